// file: inc/jcl_pkg.sv
// package for the boundary-scan configuration loader (host side)
// assumes a 50 MHz mclk and a slow tck made by dividing it
`default_nettype none
package jcl_pkg;
    // tck is mclk divided by 2*half
    localparam int unsigned JCL_CLK_HZ = 50_000_000;
    localparam int unsigned JCL_TCK_HALF = 4;
    localparam logic [2:0] JCL_HALF_MAX = 3'(JCL_TCK_HALF - 1);
    // sequence counts in tck cycles
    localparam logic [13:0] JCL_RESET_TCKS = 14'D5;
    localparam logic [13:0] JCL_TWO_TCKS = 14'D2;
    localparam logic [13:0] JCL_IR_LOW_BITS = 14'D5;
    localparam logic [13:0] JCL_IDLE_TCKS = 14'D10000;
    // instruction codes, lower five bits, top bit is zero
    localparam logic [5:0] JCL_CLEAR_CFG_INSTR = 6'H0B;
    localparam logic [5:0] JCL_LOAD_CFG_INSTR = 6'H05;
    localparam int unsigned JCL_WORD_W = 32;
    localparam int unsigned JCL_BUF_DEPTH = 2;
    typedef enum logic [3:0] {
        ST_IDLE, ST_RESET1, ST_RTI1, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR,
        ST_RESET2, ST_WAIT, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR,
        ST_UPDATE, ST_DONE
    } jcl_state_t;
endpackage
`default_nettype wire

// file: inc/jcl_buf_if.sv
// stream interface between the word buffer and the shifter
// assumes both ends on mclk
`default_nettype none
interface jcl_buf_if;
    import jcl_pkg::*;
    logic valid;
    logic ready;
    logic [JCL_WORD_W-1:0] data;
    logic last;
    modport src (output valid, output data, output last, input ready);
    modport dst (input valid, input data, input last, output ready);
endinterface
`default_nettype wire

// file: core/jcl_word_buf.sv
// two-entry word buffer with valid/ready on both sides
// assumes a single clock, synchronous reset
`default_nettype none
module jcl_word_buf
    import jcl_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [JCL_WORD_W-1:0] in_data,
    input wire logic in_last,
    jcl_buf_if.src out
);
    logic [JCL_WORD_W:0] mem_q [JCL_BUF_DEPTH];
    logic [JCL_WORD_W:0] mem_d [JCL_BUF_DEPTH];
    logic wr_q, wr_d, rd_q, rd_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;
    // ----------------------------------------------------------------
    // pointers and count
    // ----------------------------------------------------------------
    assign in_ready = (cnt_q != 2'D2);
    assign push = in_valid && in_ready;
    assign pop = out.valid && out.ready;
    assign out.valid = (cnt_q != 2'D0);
    assign out.data = mem_q[rd_q][JCL_WORD_W-1:0];
    assign out.last = mem_q[rd_q][JCL_WORD_W];
    // next state of the buffer
    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = {in_last, in_data};
            wr_d = ~wr_q;
        end
        if (pop) begin
            rd_d = ~rd_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'D1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'D1;
        end
    end
    // register the buffer
    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_q <= 1'B0;
            rd_q <= 1'B0;
            cnt_q <= 2'D0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end
endmodule
`default_nettype wire

// file: core/jcl_loader.sv
// host controller that loads a bitstream through a boundary-scan port
// assumes the device samples tms/tdi on the rising edge of tck
// Functional notes
// - Start by holding tms high five tck cycles, then one low cycle.
// - From idle drive tms high two cycles to reach instruction select.
// - Drive tms low two cycles through capture into instruction shift.
// - Shift clear-config low bits 01011 lsb first, tms low, five cycles.
// - Shift the top clear-config bit 0 in the cycle tms rises to exit.
// - Reset again with five high cycles, then idle 10000 cycles low.
// - Shift load-config low bits 00101 lsb first, tms low, five cycles.
// - Shift the top load-config bit 0 in the cycle tms rises to exit.
// - After the instruction drive tms high two cycles to data select.
// - Drive tms low two cycles through capture into data shift.
// - Shift the bitstream msb first with tms low.
// - Present the last bitstream bit together with tms high.
// - A configured device is reloaded by the same sequence after reset.
`default_nettype none
module jcl_loader
    import jcl_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic start,
    output logic busy,
    output logic done,
    input wire logic word_valid,
    output logic word_ready,
    input wire logic [JCL_WORD_W-1:0] word_data,
    input wire logic word_last,
    output logic tck,
    output logic tms,
    output logic tdi
);
    jcl_buf_if bif ();
    jcl_state_t st_q, st_d;
    logic [2:0] div_q, div_d;
    logic tck_q, tck_d, tms_q, tms_d, tdi_q, tdi_d;
    logic [13:0] cnt_q, cnt_d;
    logic load_q, load_d;          // second instruction pass
    logic [4:0] bit_q, bit_d;
    logic fall;
    logic [5:0] instr;

    // ----------------------------------------------------------------
    // word buffer
    // ----------------------------------------------------------------
    jcl_word_buf u_buf (
        .mclk(mclk),
        .reset(reset),
        .in_valid(word_valid),
        .in_ready(word_ready),
        .in_data(word_data),
        .in_last(word_last),
        .out(bif)
    );

    // step once per tck falling edge so the device sees stable pins
    function automatic logic [13:0] dec(input logic [13:0] c);
        return c - 14'D1;
    endfunction

    assign instr = load_q ? JCL_LOAD_CFG_INSTR : JCL_CLEAR_CFG_INSTR;
    assign fall = (div_q == JCL_HALF_MAX) && tck_q;
    assign busy = (st_q != ST_IDLE) && (st_q != ST_DONE);
    assign done = (st_q == ST_DONE);
    assign tck = tck_q;
    assign tms = tms_q;
    assign tdi = tdi_q;
    // word popped at the fall that puts its bit 0 on tdi; its last flag
    // rides on in tms_q, so the next word can follow with no gap bit
    assign bif.ready = fall && (st_q == ST_SHIFT_DR) && (bit_q == 5'D1);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        load_d = load_q;
        bit_d = bit_q;
        tms_d = tms_q;
        tdi_d = tdi_q;
        div_d = (div_q == JCL_HALF_MAX) ? 3'D0 : div_q + 3'D1;
        tck_d = (div_q == JCL_HALF_MAX) ? ~tck_q : tck_q;
        if (st_q == ST_IDLE || st_q == ST_DONE) begin
            div_d = 3'D0;
            tck_d = 1'B0;
            if (start) begin
                st_d = ST_RESET1;
                cnt_d = JCL_RESET_TCKS;
                load_d = 1'B0;
                tms_d = 1'B1;
                tdi_d = 1'B0;
            end
        end else if (st_q == ST_CAP_DR && cnt_q == 14'D0) begin
            // buffer ran dry in shift-dr: hold tck low, no stray shift
            div_d = 3'D0;
            tck_d = 1'B0;
            if (bif.valid) begin
                st_d = ST_SHIFT_DR;
                bit_d = 5'D31;
                tdi_d = bif.data[31];
            end
        end else if (fall) begin
            cnt_d = dec(cnt_q);
            case (st_q)
                ST_RESET1, ST_RESET2: begin
                    if (cnt_q == 14'D1) begin
                        tms_d = 1'B0;
                        st_d = (st_q == ST_RESET1) ? ST_RTI1 : ST_WAIT;
                        cnt_d = (st_q == ST_RESET1) ? 14'D1
                                                    : JCL_IDLE_TCKS;
                    end
                end
                ST_RTI1, ST_WAIT: begin
                    if (cnt_q == 14'D1) begin
                        tms_d = 1'B1;
                        st_d = ST_SEL_IR;
                        cnt_d = JCL_TWO_TCKS;
                    end
                end
                ST_SEL_IR: begin
                    if (cnt_q == 14'D1) begin
                        tms_d = 1'B0;
                        st_d = ST_CAP_IR;
                        cnt_d = JCL_TWO_TCKS;
                    end
                end
                ST_CAP_IR: begin
                    if (cnt_q == 14'D1) begin
                        st_d = ST_SHIFT_IR;
                        cnt_d = JCL_IR_LOW_BITS;
                        tdi_d = instr[0];
                        bit_d = 5'D1;
                    end
                end
                ST_SHIFT_IR: begin
                    bit_d = bit_q + 5'D1;
                    if (bit_q == 5'D6) begin
                        tms_d = 1'B1;
                        if (load_q) begin
                            st_d = ST_SEL_DR;
                            cnt_d = JCL_TWO_TCKS;
                        end else begin
                            st_d = ST_RESET2;
                            cnt_d = JCL_RESET_TCKS;
                            load_d = 1'B1;
                        end
                    end else begin
                        tdi_d = instr[bit_q[2:0]];
                        tms_d = (bit_q == 5'D5);
                    end
                end
                ST_SEL_DR: begin
                    // sel-dr-scan reached after exit1-ir and update-ir
                    if (cnt_q == 14'D1) begin
                        tms_d = 1'B0;
                        st_d = ST_CAP_DR;
                        cnt_d = JCL_TWO_TCKS;
                    end
                end
                ST_CAP_DR: begin
                    if (cnt_q == 14'D1 && bif.valid) begin
                        st_d = ST_SHIFT_DR;
                        bit_d = 5'D31;
                        tdi_d = bif.data[31];
                        tms_d = 1'B0;
                    end else if (cnt_q == 14'D1) begin
                        cnt_d = 14'D0;      // no word yet: stall tck
                    end
                end
                ST_SHIFT_DR: begin
                    if (bit_q != 5'D0) begin
                        bit_d = bit_q - 5'D1;
                        tdi_d = bif.data[bit_q - 5'D1];
                        tms_d = bif.last && (bit_q == 5'D1);
                    end else if (tms_q) begin
                        tms_d = 1'B1;       // exit1 to update
                        st_d = ST_UPDATE;
                        cnt_d = 14'D1;
                    end else if (bif.valid) begin
                        bit_d = 5'D31;      // next word follows directly
                        tdi_d = bif.data[31];
                    end else begin
                        st_d = ST_CAP_DR;   // wait for next word, tck held
                        cnt_d = 14'D0;
                    end
                end
                ST_UPDATE: begin
                    tms_d = 1'B0;
                    st_d = ST_DONE;
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_q <= ST_IDLE;
            div_q <= 3'D0;
            tck_q <= 1'B0;
            tms_q <= 1'B1;
            tdi_q <= 1'B0;
            cnt_q <= 14'D0;
            load_q <= 1'B0;
            bit_q <= 5'D0;
        end else begin
            st_q <= st_d;
            div_q <= div_d;
            tck_q <= tck_d;
            tms_q <= tms_d;
            tdi_q <= tdi_d;
            cnt_q <= cnt_d;
            load_q <= load_d;
            bit_q <= bit_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_reset_tms_high: assert property (@(posedge mclk) disable iff (reset)
        (st_q == ST_RESET1) |-> tms_q)
        else $error("tms low during reset walk");
    chk_idle_tms_low: assert property (@(posedge mclk) disable iff (reset)
        (st_q == ST_WAIT) |-> !tms_q)
        else $error("tms high during idle wait");
    chk_selir_tms: assert property (@(posedge mclk) disable iff (reset)
        (st_q == ST_SEL_IR) |-> tms_q)
        else $error("tms low in ir select");
    chk_capir_tms: assert property (@(posedge mclk) disable iff (reset)
        (st_q == ST_CAP_IR) |-> !tms_q)
        else $error("tms high in ir capture");
    chk_ir_msb_zero: assert property (@(posedge mclk) disable iff (reset)
        (st_q == ST_SHIFT_IR && tms_q) |-> !tdi_q)
        else $error("instruction top bit not zero");
    chk_ir_top_load: assert property (@(posedge mclk) disable iff (reset)
        (st_q == ST_SHIFT_IR && tms_q && load_q) |-> !tdi_q)
        else $error("load instruction top bit not zero");
    chk_seldr_tms: assert property (@(posedge mclk) disable iff (reset)
        (st_q == ST_SEL_DR) |-> tms_q)
        else $error("tms low in dr select");
    chk_capdr_tms: assert property (@(posedge mclk) disable iff (reset)
        (st_q == ST_CAP_DR) |-> !tms_q)
        else $error("tms high in dr capture");
    chk_dr_shift_tms: assert property (@(posedge mclk) disable iff (reset)
        (st_q == ST_SHIFT_DR && bit_q != 5'D0) |-> !tms_q)
        else $error("tms high mid word");
    chk_stall_tck_low: assert property (@(posedge mclk) disable iff (reset)
        (st_q == ST_CAP_DR && cnt_q == 14'D0) |-> !tck_q)
        else $error("tck high while waiting for a word");
endmodule
`default_nettype wire

// file: tb/jcl_dev_model.sv
// behavioural device end of the boundary-scan port: tap controller,
// instruction register and configuration data sink
// assumes tck, tms and tdi come from the loader; no tdo is modelled
`default_nettype none
module jcl_dev_model
    import jcl_pkg::*;
(
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // tap controller and sinks
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TLR, RTI, SDR, CDR, SHDR, E1DR, PDR, E2DR, UDR,
        SIR, CIR, SHIR, E1IR, PIR, E2IR, UIR
    } jcl_tap_t;
    jcl_tap_t st = TLR;
    logic [5:0] ir_sh = 6'H00;
    logic [5:0] ir_q = 6'H00;
    logic [31:0] dr_sh = 32'H0;
    logic [31:0] rx_mem [0:7];
    int clr_cnt = 0;
    int wait_cnt = 0;
    int wait_at_load = 0;
    int rx_cnt = 0;
    int upd_cnt = 0;

    // standard tap transitions on tms
    function automatic jcl_tap_t tap_next(input jcl_tap_t s, input logic m);
        case (s)
            TLR: return m ? TLR : RTI;
            RTI, UDR, UIR: return m ? SDR : RTI;
            SDR: return m ? SIR : CDR;
            CDR, SHDR: return m ? E1DR : SHDR;
            E1DR: return m ? UDR : PDR;
            PDR: return m ? E2DR : PDR;
            E2DR: return m ? UDR : SHDR;
            SIR: return m ? TLR : CIR;
            CIR, SHIR: return m ? E1IR : SHIR;
            E1IR: return m ? UIR : PIR;
            PIR: return m ? E2IR : PIR;
            default: return m ? UIR : SHIR;
        endcase
    endfunction

    // device samples tms and tdi on the rising edge of tck
    always @(posedge tck) begin
        if (st == SHIR) ir_sh <= {tdi, ir_sh[5:1]}; // lsb arrives first
        if (st == SHDR && ir_q == JCL_LOAD_CFG_INSTR) begin
            dr_sh <= {dr_sh[30:0], tdi};
            if (rx_cnt % 32 == 31)
                rx_mem[(rx_cnt / 32) % 8] <= {dr_sh[30:0], tdi};
            rx_cnt <= rx_cnt + 1;
        end
        // update-dr counted on entry: the loader stops tck once there
        if (tap_next(st, tms) == UDR && ir_q == JCL_LOAD_CFG_INSTR)
            upd_cnt <= upd_cnt + 1;
        if ((st == TLR || st == RTI) && !tms) wait_cnt <= wait_cnt + 1;
        if (st == UIR) begin
            ir_q <= ir_sh;
            // clearing zeroes the wait, bit and update counts, so a configured device reloads
            if (ir_sh == JCL_CLEAR_CFG_INSTR) begin
                clr_cnt <= clr_cnt + 1;
                wait_cnt <= 0;
                rx_cnt <= 0;
                upd_cnt <= 0;
            end
            if (ir_sh == JCL_LOAD_CFG_INSTR) wait_at_load <= wait_cnt;
        end
        st <= tap_next(st, tms);
    end
endmodule
`default_nettype wire

// file: tb/test_jcl_loader.sv
// self-checking bench for the boundary-scan configuration loader
// assumes the device model in jcl_dev_model and a 50 MHz mclk
`default_nettype none
module test_jcl_loader
    import jcl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // stimulus, device and checks
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic word_valid = 1'b0;
    logic [31:0] word_data = 32'H0;
    logic word_last = 1'b0;
    logic busy, done, word_ready, tck, tms, tdi;
    int failures = 0;
    int n_tests = 0;
    logic [31:0] words [0:2] = '{32'HA5C3_0F01, 32'H8000_0001,
        32'H7FFE_1234};

    jcl_loader dut_u (.mclk(mclk), .reset(reset), .start(start),
        .busy(busy), .done(done), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data),
        .word_last(word_last), .tck(tck), .tms(tms), .tdi(tdi));
    jcl_dev_model dev_u (.tck(tck), .tms(tms), .tdi(tdi));

    // 20 ns system clock
    always #10 mclk = ~mclk;

    task automatic chk_bit(input logic got, input logic exp, input string m);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h", $time, m, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // pins at rest after reset, sampled away from the edge
    task automatic chk_rest();
        @(negedge mclk);
        chk_bit(tck, 1'b0, "tck not low at rest");
        chk_bit(tms, 1'b1, "tms not high at rest");
        chk_bit(tdi, 1'b0, "tdi not low at rest");
        chk_bit(busy, 1'b0, "busy at rest");
        chk_bit(word_ready, 1'b1, "buffer not ready at rest");
        @(posedge mclk);
    endtask

    task automatic pulse_start();
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
    endtask

    // hold a word until ready is seen high at a falling edge
    task automatic push(input logic [31:0] d, input logic l, input int lim,
        output bit ok);
        @(posedge mclk);    // let an edge pass after a previous push
        word_valid <= 1'b1;
        word_data <= d;
        word_last <= l;
        ok = 0;
        for (int i = 0; i < lim && !ok; i++) begin
            @(negedge mclk);
            ok = (word_ready === 1'b1);
        end
        @(posedge mclk);
        word_valid <= 1'b0;
    endtask

    // reset in mid-load after the clear instruction went in
    task automatic t_abort();
        pulse_start();
        repeat (400) @(posedge mclk);
        @(negedge mclk);
        chk_bit(busy, 1'b1, "not busy during load");
        chk_word(32'(dev_u.clr_cnt), 32'H1, "clear not taken");
        chk_word(32'(dev_u.ir_q), 32'(JCL_CLEAR_CFG_INSTR),
            "clear code");
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        chk_rest();
    endtask

    // fill the buffer until it refuses a word
    task automatic t_fill(output int k);
        bit ok;
        k = 0;
        for (int i = 0; i < 3; i++) begin
            push(words[i], 1'b0, 20, ok);
            if (ok) k++;
        end
        chk_word(32'(k), 32'H2, "buffer depth");
    endtask

    // full load with a refused second start and a late last word
    task automatic t_load();
        bit ok;
        pulse_start();
        repeat (60) @(posedge mclk);
        pulse_start();
        // hold the last word back until the buffer has run dry in shift-dr
        for (int i = 0; i < 90000 && dev_u.rx_cnt < 64; i++) @(posedge mclk);
        repeat (40) @(posedge mclk);
        @(negedge mclk);
        chk_bit(tck, 1'b0, "tck runs while dry");
        chk_word(32'(dev_u.rx_cnt), 32'H40, "stray bit while dry");
        push(words[2], 1'b1, 90000, ok);
        chk_bit(ok, 1'b1, "last word never taken");
        for (int i = 0; i < 90000 && done !== 1'b1; i++) @(posedge mclk);
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        chk_bit(done, 1'b1, "load not done");
        chk_bit(busy, 1'b0, "busy after load");
        chk_bit(tck, 1'b0, "tck runs after load");
        chk_word(32'(dev_u.clr_cnt), 32'H2, "clear count");
        chk_word(32'(dev_u.ir_q), 32'(JCL_LOAD_CFG_INSTR),
            "load code");
        chk_word(32'(dev_u.wait_at_load), 32'(JCL_IDLE_TCKS),
            "idle wait");
        chk_word(32'(dev_u.rx_cnt), 32'H60, "bit count");
        for (int i = 0; i < 3; i++) begin
            chk_word(dev_u.rx_mem[i], words[i], "word");
        end
        chk_word(32'(dev_u.upd_cnt), 32'H1, "data update count");
    endtask

    // main sequence
    initial begin
        int k;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        chk_rest();
        t_abort();
        t_fill(k);
        t_load();
        wrap_up();
    end

    // watchdog sized for one abort and one full load
    initial begin
        repeat (95000) @(posedge mclk);
        failures++;
        wrap_up();
    end
endmodule
`default_nettype wire
